// >>> src/dac_mode_control_regs.sv
// Purpose: mode-control register bank and control outputs of a stereo dac
// Assumes: serial port logic hands over whole 16-bit frames on mclk
// Notes: one soft reset pulse reinitialises registers and the datapath
`timescale 1ns/100ps
module dac_mode_control_regs #(
  // device identifier, value arbitrary
  parameter logic [4:0] DEVICE_ID = 5'h01
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control frame port
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  output logic read_valid,
  output logic [7:0] read_data,
  // zero detector results, same clock
  input wire dac_mode_pkg::zero_det_t zero_det_l,
  input wire dac_mode_pkg::zero_det_t zero_det_r,
  input wire logic both_channels_zero,
  // flag pins, shared with bypass stereo data
  input wire logic left_flag_pin_in,
  input wire logic right_flag_pin_in,
  output logic left_flag_pin_out,
  output logic right_flag_pin_out,
  output logic flag_pins_oe_n,
  // single data pin in filter bypass mode
  input wire logic data_pin_in,
  // control outputs
  output dac_mode_pkg::mode_ctl_t mode_ctl,
  output logic soft_reset_pulse,
  output logic force_bipolar_midscale,
  output logic zero_hold_mute_active,
  output logic filter_slow_rolloff,
  output logic internal_filter_on,
  output logic stream_path_on,
  output logic bypass_data_l,
  output logic bypass_data_r,
  output logic bypass_single_channel_mode_in,
  output logic balanced_single_channel_mode,
  output logic single_channel_mode_right_sel,
  output logic [7:0] osr_ratio,
  output dac_mode_pkg::mod_rate_t stream_bclk_speed,
  output logic rate_reserved
);

  // frame fields
  logic frame_rw;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic wr_en;
  logic rd_en;

  // internal reset from power-on or soft reset
  logic sys_rst;
  logic soft_rst_q;

  // register state
  logic out_disable_q;
  logic byp_stereo_q;
  logic rolloff_q;
  logic zhold_q;
  logic stream_q;
  logic extf_q;
  logic single_channel_mode_q;
  logic chpick_q;
  dac_mode_pkg::mod_rate_t rate_q;
  logic [1:0] zpat_q;
  logic zfen_q;

  // flag state
  logic flag_l_d;
  logic flag_r_d;
  logic flag_l_q;
  logic flag_r_q;

  // synchronised pins
  logic left_pin_s;
  logic right_pin_s;
  logic data_pin_s;

  // pins act as data inputs in this mode
  logic pins_are_data;

  // read mux value
  logic [7:0] rd_mux;

  // split the frame
  assign frame_rw = frame_word[dac_mode_pkg::RW_BIT];
  assign frame_addr = frame_word[dac_mode_pkg::ADDR_HI:dac_mode_pkg::ADDR_LO];
  assign frame_data = frame_word[dac_mode_pkg::DATA_W-1:0];
  assign wr_en = frame_valid && (frame_rw == dac_mode_pkg::RW_WRITE);
  assign rd_en = frame_valid && (frame_rw == dac_mode_pkg::RW_READ);

  // soft reset: one pulse per write of 1, bit never stored for reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      soft_rst_q <= 1'h0;
    end else begin
      soft_rst_q <= wr_en && (frame_addr == dac_mode_pkg::ADDR_MODE_SELECT) &&
                    frame_data[dac_mode_pkg::SOFT_RST_POS];
    end
  end

  assign soft_reset_pulse = soft_rst_q;
  assign sys_rst = rst || soft_rst_q;

  // output control register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_disable_q <= dac_mode_pkg::RST_OUT_DISABLE;
      byp_stereo_q <= dac_mode_pkg::RST_BYP_STEREO;
      rolloff_q <= dac_mode_pkg::RST_ROLLOFF;
      zhold_q <= dac_mode_pkg::RST_ZHOLD;
    end else if (wr_en && frame_addr == dac_mode_pkg::ADDR_OUTPUT_CONTROL) begin
      // unused bits of the frame are dropped
      out_disable_q <= frame_data[dac_mode_pkg::OUT_DISABLE_POS];
      byp_stereo_q <= frame_data[dac_mode_pkg::BYP_STEREO_POS];
      rolloff_q <= frame_data[dac_mode_pkg::ROLLOFF_POS];
      zhold_q <= frame_data[dac_mode_pkg::ZHOLD_POS];
    end
  end

  // mode select register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stream_q <= dac_mode_pkg::RST_STREAM;
      extf_q <= dac_mode_pkg::RST_EXTF;
      single_channel_mode_q <= dac_mode_pkg::RST_SINGLE_CHANNEL_MODE;
      chpick_q <= dac_mode_pkg::RST_CHPICK;
      rate_q <= dac_mode_pkg::mod_rate_t'(dac_mode_pkg::RST_RATE);
    end else if (wr_en && frame_addr == dac_mode_pkg::ADDR_MODE_SELECT) begin
      stream_q <= frame_data[dac_mode_pkg::STREAM_POS];
      extf_q <= frame_data[dac_mode_pkg::EXTF_POS];
      single_channel_mode_q <= frame_data[dac_mode_pkg::SINGLE_CHANNEL_MODE_POS];
      chpick_q <= frame_data[dac_mode_pkg::CHPICK_POS];
      // reserved code 11 is stored but flagged
      rate_q <= dac_mode_pkg::mod_rate_t'(
        frame_data[dac_mode_pkg::RATE_LO+1:dac_mode_pkg::RATE_LO]);
    end
  end

  // zero output control register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      zpat_q <= dac_mode_pkg::RST_ZPAT;
      zfen_q <= dac_mode_pkg::RST_ZFEN;
    end else if (wr_en && frame_addr == dac_mode_pkg::ADDR_ZERO_OUTPUT) begin
      zpat_q <= frame_data[dac_mode_pkg::ZPAT_LO+1:dac_mode_pkg::ZPAT_LO];
      zfen_q <= frame_data[dac_mode_pkg::ZFEN_POS];
    end
  end

  // zero flag selection per mode
  always_comb begin
    flag_l_d = 1'h0;
    flag_r_d = 1'h0;
    if (stream_q) begin
      // stream mode: pattern select decides, code 00 keeps flags off
      if (zpat_q == dac_mode_pkg::ZPAT_EVEN) begin
        flag_l_d = zero_det_l.even_pattern;
        flag_r_d = zero_det_r.even_pattern;
      end else if (zpat_q != dac_mode_pkg::ZPAT_OFF) begin
        flag_l_d = zero_det_l.pattern_96;
        flag_r_d = zero_det_r.pattern_96;
      end
    end else begin
      // pcm and external filter modes
      flag_l_d = zfen_q && zero_det_l.pcm_zero;
      flag_r_d = zfen_q && zero_det_r.pcm_zero;
    end
  end

  // registered flags drive pins and status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_l_q <= 1'h0;
      flag_r_q <= 1'h0;
    end else begin
      flag_l_q <= flag_l_d;
      flag_r_q <= flag_r_d;
    end
  end

  // flag pins turn into data inputs in stereo filter bypass
  assign pins_are_data = extf_q && byp_stereo_q;
  assign flag_pins_oe_n = pins_are_data;
  assign left_flag_pin_out = pins_are_data ? 1'h0 : flag_l_q;
  assign right_flag_pin_out = pins_are_data ? 1'h0 : flag_r_q;

  // pin inputs cross into mclk
  pin_sync u_sync_left (
    .mclk(mclk),
    .rst(rst),
    .pin_in(left_flag_pin_in),
    .pin_sync_out(left_pin_s)
  );

  pin_sync u_sync_right (
    .mclk(mclk),
    .rst(rst),
    .pin_in(right_flag_pin_in),
    .pin_sync_out(right_pin_s)
  );

  pin_sync u_sync_data (
    .mclk(mclk),
    .rst(rst),
    .pin_in(data_pin_in),
    .pin_sync_out(data_pin_s)
  );

  // bypass data routing, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bypass_data_l <= 1'h0;
      bypass_data_r <= 1'h0;
      bypass_single_channel_mode_in <= 1'h0;
    end else if (extf_q) begin
      if (byp_stereo_q) begin
        // stereo: left and right on the flag pins
        bypass_data_l <= left_pin_s;
        bypass_data_r <= right_pin_s;
        bypass_single_channel_mode_in <= 1'h0;
      end else begin
        // monaural: single data pin feeds both
        bypass_data_l <= data_pin_s;
        bypass_data_r <= data_pin_s;
        bypass_single_channel_mode_in <= 1'h1;
      end
    end else begin
      // external filter bypass off, bypass path idle
      bypass_data_l <= 1'h0;
      bypass_data_r <= 1'h0;
      bypass_single_channel_mode_in <= 1'h0;
    end
  end

  // output forcing and mode decode, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      zero_hold_mute_active <= 1'h0;
      force_bipolar_midscale <= 1'h0;
      filter_slow_rolloff <= 1'h0;
      internal_filter_on <= 1'h1;
      stream_path_on <= 1'h0;
      balanced_single_channel_mode <= 1'h0;
      single_channel_mode_right_sel <= 1'h0;
    end else begin
      // zero hold never acts in stream mode
      zero_hold_mute_active <= zhold_q && !stream_q &&
                               both_channels_zero;
      force_bipolar_midscale <= out_disable_q ||
                                (zhold_q && !stream_q &&
                                 both_channels_zero);
      filter_slow_rolloff <= rolloff_q;
      internal_filter_on <= !extf_q && !stream_q;
      stream_path_on <= stream_q;
      balanced_single_channel_mode <= single_channel_mode_q;
      // channel pick matters only in single mode
      single_channel_mode_right_sel <= single_channel_mode_q && chpick_q;
    end
  end

  // rate decode, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      osr_ratio <= dac_mode_pkg::OSR_64;
      stream_bclk_speed <= dac_mode_pkg::RATE_X64;
      rate_reserved <= 1'h0;
    end else begin
      // stream mode: field gives bit clock speed instead
      stream_bclk_speed <= stream_q ? rate_q :
                           dac_mode_pkg::RATE_X64;
      rate_reserved <= (rate_q == dac_mode_pkg::RATE_RSVD);
      if (stream_q) begin
        osr_ratio <= dac_mode_pkg::OSR_NONE;
      end else begin
        unique case (rate_q)
          dac_mode_pkg::RATE_X64: begin
            osr_ratio <= dac_mode_pkg::OSR_64;
          end
          dac_mode_pkg::RATE_X32: begin
            osr_ratio <= dac_mode_pkg::OSR_32;
          end
          dac_mode_pkg::RATE_X128: begin
            // host keeps this to low rates and fast clocks
            osr_ratio <= dac_mode_pkg::OSR_128;
          end
          dac_mode_pkg::RATE_RSVD: begin
            osr_ratio <= dac_mode_pkg::OSR_NONE;
          end
        endcase
      end
    end
  end

  // control bundle, packed in the field order of the struct
  assign mode_ctl = {out_disable_q, byp_stereo_q, rolloff_q, zhold_q,
                     stream_q, extf_q, single_channel_mode_q, chpick_q, rate_q, zpat_q,
                     zfen_q};

  // read mux, reserved bits zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (frame_addr)
      dac_mode_pkg::ADDR_OUTPUT_CONTROL: begin
        rd_mux[dac_mode_pkg::OUT_DISABLE_POS] = out_disable_q;
        rd_mux[dac_mode_pkg::BYP_STEREO_POS] = byp_stereo_q;
        rd_mux[dac_mode_pkg::ROLLOFF_POS] = rolloff_q;
        rd_mux[dac_mode_pkg::ZHOLD_POS] = zhold_q;
      end
      dac_mode_pkg::ADDR_MODE_SELECT: begin
        // soft reset bit reads zero
        rd_mux[dac_mode_pkg::STREAM_POS] = stream_q;
        rd_mux[dac_mode_pkg::EXTF_POS] = extf_q;
        rd_mux[dac_mode_pkg::SINGLE_CHANNEL_MODE_POS] = single_channel_mode_q;
        rd_mux[dac_mode_pkg::CHPICK_POS] = chpick_q;
        rd_mux[dac_mode_pkg::RATE_LO+1:dac_mode_pkg::RATE_LO] = rate_q;
      end
      dac_mode_pkg::ADDR_ZERO_OUTPUT: begin
        rd_mux[dac_mode_pkg::ZPAT_LO+1:dac_mode_pkg::ZPAT_LO] = zpat_q;
        rd_mux[dac_mode_pkg::ZFEN_POS] = zfen_q;
      end
      dac_mode_pkg::ADDR_ZERO_STATUS: begin
        // mirror what the pins show
        rd_mux[dac_mode_pkg::ZFL_POS] = left_flag_pin_out;
        rd_mux[dac_mode_pkg::ZFR_POS] = right_flag_pin_out;
      end
      dac_mode_pkg::ADDR_DEVICE_ID: begin
        rd_mux[dac_mode_pkg::ID_W-1:0] = DEVICE_ID;
      end
      default: begin
        // unmapped register reads zero
        rd_mux = 8'h00;
      end
    endcase
  end

  // read answer one cycle after the frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_valid <= 1'h0;
      read_data <= dac_mode_pkg::RST_READ_DATA;
    end else begin
      read_valid <= rd_en;
      if (rd_en) begin
        read_data <= rd_mux;
      end
    end
  end

endmodule : dac_mode_control_regs

// >>> src/dac_mode_pkg.sv
// Purpose: shared constants and types of the dac mode-control register bank
// Assumes: 16-bit control frames, 7-bit register address, 8-bit data
// Notes: addresses are frame register numbers, not byte addresses
package dac_mode_pkg;

  // frame layout
  localparam int FRAME_W = 16;
  localparam int RW_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;

  // register numbers
  localparam logic [6:0] ADDR_OUTPUT_CONTROL = 7'h13;
  localparam logic [6:0] ADDR_MODE_SELECT = 7'h14;
  localparam logic [6:0] ADDR_ZERO_OUTPUT = 7'h15;
  localparam logic [6:0] ADDR_ZERO_STATUS = 7'h16;
  localparam logic [6:0] ADDR_DEVICE_ID = 7'h17;

  // output control register fields
  localparam int OUT_DISABLE_POS = 4;
  localparam int BYP_STEREO_POS = 2;
  localparam int ROLLOFF_POS = 1;
  localparam int ZHOLD_POS = 0;

  // mode select register fields
  localparam int SOFT_RST_POS = 6;
  localparam int STREAM_POS = 5;
  localparam int EXTF_POS = 4;
  localparam int SINGLE_CHANNEL_MODE_POS = 3;
  localparam int CHPICK_POS = 2;
  localparam int RATE_LO = 0;

  // zero output register fields
  localparam int ZPAT_LO = 1;
  localparam int ZFEN_POS = 0;

  // status and id fields
  localparam int ZFL_POS = 0;
  localparam int ZFR_POS = 1;
  localparam int ID_W = 5;

  // reset values
  localparam logic RST_OUT_DISABLE = 1'h0;
  localparam logic RST_BYP_STEREO = 1'h0;
  localparam logic RST_ROLLOFF = 1'h0;
  localparam logic RST_ZHOLD = 1'h0;
  localparam logic RST_STREAM = 1'h0;
  localparam logic RST_EXTF = 1'h0;
  localparam logic RST_SINGLE_CHANNEL_MODE = 1'h0;
  localparam logic RST_CHPICK = 1'h0;
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic [1:0] RST_ZPAT = 2'h0;
  localparam logic RST_ZFEN = 1'h1;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // modulator rate codes
  typedef enum logic [1:0] {
    RATE_X64 = 2'h0,
    RATE_X32 = 2'h1,
    RATE_X128 = 2'h2,
    RATE_RSVD = 2'h3
  } mod_rate_t;

  // oversampling ratios reported beside the code
  localparam logic [7:0] OSR_64 = 8'h40;
  localparam logic [7:0] OSR_32 = 8'h20;
  localparam logic [7:0] OSR_128 = 8'h80;
  localparam logic [7:0] OSR_NONE = 8'h00;

  // stream zero-pattern codes
  localparam logic [1:0] ZPAT_OFF = 2'h0;
  localparam logic [1:0] ZPAT_EVEN = 2'h1;

  // control bits carried to the datapath
  typedef struct packed {
    logic output_disable;
    logic bypass_stereo_sel;
    logic filter_rolloff_sel;
    logic zero_hold_mute_en;
    logic one_bit_stream_mode;
    logic ext_filter_bypass;
    logic single_channel_mode;
    logic channel_pick;
    mod_rate_t modulator_rate_sel;
    logic [1:0] stream_zero_pattern_sel;
    logic zero_flag_enable;
  } mode_ctl_t;

  // per-channel zero detector results
  typedef struct packed {
    logic pcm_zero;
    logic even_pattern;
    logic pattern_96;
  } zero_det_t;

endpackage : dac_mode_pkg

// >>> src/pin_sync.sv
// Purpose: two-flop synchroniser for one pin input
// Assumes: pin is asynchronous to mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin side
  input wire logic pin_in,
  // synchronous side
  output logic pin_sync_out
);

  logic meta_q; // first stage, read only by second stage

  // two stage capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'h0;
      pin_sync_out <= 1'h0;
    end else begin
      meta_q <= pin_in;
      pin_sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// >>> verif/dac_mode_props.sv
// Purpose: port checks for the mode-control register bank
// Assumes: one mclk domain, synchronous active-high rst
// Notes: soft reset cycles are left out of register-follow checks
`timescale 1ns/100ps
module dac_mode_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // frame port
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  input wire logic read_valid,
  // status input and controls
  input wire logic both_channels_zero,
  input wire dac_mode_pkg::mode_ctl_t mode_ctl,
  input wire logic soft_reset_pulse,
  input wire logic force_bipolar_midscale,
  input wire logic zero_hold_mute_active,
  input wire logic internal_filter_on,
  input wire logic single_channel_mode_right_sel,
  input wire logic [7:0] osr_ratio
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] exp_osr; // ratio the rate field asks for
  logic wr_out; // write frame to the output control register
  logic wr_soft_rst; // write frame setting the soft reset bit
  logic srp; // soft reset pulse alias
  logic exp_filter; // internal filter wanted by the mode bits
  logic exp_right; // right channel picked in single mode
  assign exp_filter = !mode_ctl.ext_filter_bypass &&
    !mode_ctl.one_bit_stream_mode;
  assign exp_right = mode_ctl.single_channel_mode && mode_ctl.channel_pick;
  assign srp = soft_reset_pulse;
  assign wr_out = frame_valid && !frame_word[15] &&
    frame_word[14:8] == 7'h13;
  assign wr_soft_rst = frame_valid && !frame_word[15] &&
    frame_word[14:8] == 7'h14 && frame_word[6];
  // expected ratio, none for the reserved code or stream mode
  always_comb begin
    case (mode_ctl.modulator_rate_sel)
      dac_mode_pkg::RATE_X64: exp_osr = 8'h40;
      dac_mode_pkg::RATE_X32: exp_osr = 8'h20;
      dac_mode_pkg::RATE_X128: exp_osr = 8'h80;
      default: exp_osr = 8'h00;
    endcase
    if (mode_ctl.one_bit_stream_mode) begin
      exp_osr = 8'h00;
    end
  end
  AST_RD_ANSWER: assert property (frame_valid && frame_word[15] |=>
    read_valid) else $error("read frame got no answer");
  AST_RD_ONLY: assert property (!(frame_valid && frame_word[15]) |=>
    !read_valid) else $error("answer without read frame");
  AST_WR_APPLY: assert property (wr_out && !srp |=>
    mode_ctl.output_disable == $past(frame_word[4]))
    else $error("output disable not written");
  AST_SOFT_RST: assert property (wr_soft_rst && !srp |=>
    srp ##1 !srp) else $error("soft reset not a single pulse");
  AST_SOFT_RST_CAUSE: assert property ($rose(srp) |->
    $past(wr_soft_rst)) else $error("soft reset pulse without write");
  AST_DISABLE: assert property (mode_ctl.output_disable && !srp |=>
    force_bipolar_midscale) else $error("outputs not at midscale");
  AST_ZHOLD: assert property (mode_ctl.zero_hold_mute_en && !srp &&
    !mode_ctl.one_bit_stream_mode && both_channels_zero |=>
    zero_hold_mute_active) else $error("zero hold mute missing");
  AST_ZHOLD_STREAM: assert property (mode_ctl.one_bit_stream_mode |=>
    !zero_hold_mute_active) else $error("mute active in stream mode");
  AST_RATE: assert property (!srp |=> osr_ratio == $past(exp_osr))
    else $error("oversampling ratio wrong");
  AST_FILTER: assert property (!srp |=> internal_filter_on ==
    $past(exp_filter)) else $error("internal filter state wrong");
  AST_SINGLE_CHANNEL_MODE: assert property (!srp |=> single_channel_mode_right_sel ==
    $past(exp_right)) else $error("single_channel_mode channel pick wrong");
endmodule : dac_mode_props

bind dac_mode_control_regs dac_mode_props i_props (
  .mclk(mclk), .rst(rst), .frame_valid(frame_valid),
  .frame_word(frame_word), .read_valid(read_valid),
  .both_channels_zero(both_channels_zero), .mode_ctl(mode_ctl),
  .soft_reset_pulse(soft_reset_pulse),
  .force_bipolar_midscale(force_bipolar_midscale),
  .zero_hold_mute_active(zero_hold_mute_active),
  .internal_filter_on(internal_filter_on),
  .single_channel_mode_right_sel(single_channel_mode_right_sel), .osr_ratio(osr_ratio));

// >>> verif/host_model.sv
// Purpose: host controller sending whole control frames
// Assumes: frames change at the falling edge, taken at the rising edge
// Notes: a released word shows its inverse, never the last value
`timescale 1ns/100ps
module host_model #(
  // system runs at low sample rate with a fast system clock
  parameter bit LOW_RATE_FAST_CLK = 1'h1
) (
  // clock
  input wire logic mclk,
  // frame port
  output logic frame_valid,
  output logic [15:0] frame_word,
  input wire logic read_valid,
  input wire logic [7:0] read_data
);
  initial begin
    frame_valid = 1'h0;
    frame_word = 16'h0000;
  end
  // one frame held over one rising edge; top bit picks read
  task automatic send(input logic rd, input logic [6:0] a,
    input logic [7:0] d);
    @(negedge mclk);
    frame_word = {rd, a, d};
    frame_valid = 1'h1;
    @(negedge mclk);
    frame_valid = 1'h0;
    frame_word = ~frame_word;
  endtask : send
  // write; the 128x code only where the clocks allow it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 7'h14 && d[1:0] == 2'h2 && !LOW_RATE_FAST_CLK) begin
      v[1:0] = 2'h0;
    end
    send(1'h0, a, v);
  endtask : wr
  // read; answer taken one cycle after the frame
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
    output logic v);
    send(1'h1, a, 8'h00);
    d = read_data;
    v = read_valid;
  endtask : rd
endmodule : host_model

// >>> verif/tb_top.sv
// Purpose: directed test of the mode-control register bank
// Assumes: host model drives frames, bench drives flag and zero inputs
// Notes: expectations come from the register map
`timescale 1ns/100ps
module tb_top;
  localparam logic [4:0] ID = 5'h0B; // arbitrary identifier
  logic mclk, rst, fv, rv, srp, fbm, zhm, fsr, ifo, spo;
  logic bl, br, bmi, bal, mrs, rr, lpin, rpin, dpin, lout, rout, oe_n, bz;
  logic [15:0] fw;
  logic [7:0] rdat, osr;
  dac_mode_pkg::zero_det_t zd_l, zd_r;
  dac_mode_pkg::mode_ctl_t mctl;
  dac_mode_pkg::mod_rate_t bck;
  int failures = 0;
  int tests_run = 0;
  dac_mode_control_regs #(.DEVICE_ID(ID)) i_dut (.mclk(mclk), .rst(rst),
    .frame_valid(fv), .frame_word(fw), .read_valid(rv), .read_data(rdat),
    .zero_det_l(zd_l), .zero_det_r(zd_r), .both_channels_zero(bz),
    .left_flag_pin_in(lpin), .right_flag_pin_in(rpin),
    .left_flag_pin_out(lout), .right_flag_pin_out(rout),
    .flag_pins_oe_n(oe_n), .data_pin_in(dpin), .mode_ctl(mctl),
    .soft_reset_pulse(srp), .force_bipolar_midscale(fbm),
    .zero_hold_mute_active(zhm), .filter_slow_rolloff(fsr),
    .internal_filter_on(ifo), .stream_path_on(spo), .bypass_data_l(bl),
    .bypass_data_r(br), .bypass_single_channel_mode_in(bmi), .balanced_single_channel_mode(bal),
    .single_channel_mode_right_sel(mrs), .osr_ratio(osr), .stream_bclk_speed(bck),
    .rate_reserved(rr));
  host_model i_host (.mclk(mclk), .frame_valid(fv), .frame_word(fw),
    .read_valid(rv), .read_data(rdat));
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] s,
    input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host.rd(a, d, v);
    chk("read_valid", {7'h00, v}, 8'h01);
    chk("read_data", d, e);
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    give_verdict();
  end
  initial begin
    rst = 1'h1;
    bz = 1'h0;
    lpin = 1'h0;
    rpin = 1'h0;
    dpin = 1'h0;
    zd_l = 3'h0;
    zd_r = 3'h0;
    tick(12);
    rst = 1'h0;
    rdchk(7'h13, 8'h00);
    rdchk(7'h14, 8'h00);
    rdchk(7'h15, 8'h01);
    rdchk(7'h17, {3'h0, ID});
    rdchk(7'h20, 8'h00);
    chk("osr", osr, 8'h40);
    $display("test defaults done");
    i_host.wr(7'h13, 8'hFF);
    tick(1);
    rdchk(7'h13, 8'h17);
    chk("midscale", {7'h00, fbm}, 8'h01);
    chk("rolloff", {7'h00, fsr}, 8'h01);
    i_host.wr(7'h13, 8'h00);
    tick(1);
    chk("midscale", {7'h00, fbm}, 8'h00);
    chk("rolloff", {7'h00, fsr}, 8'h00);
    $display("test output control done");
    for (int i = 0; i < 4; i++) begin
      i_host.wr(7'h14, 8'h80 | 8'(i));
      tick(1);
      chk("osr", osr, (i == 0) ? 8'h40 : (i == 1) ? 8'h20 :
        (i == 2) ? 8'h80 : 8'h00);
      chk("rate_rsvd", {7'h00, rr}, 8'(i == 3));
      rdchk(7'h14, 8'(i));
      i_host.wr(7'h14, 8'h20 | 8'(i));
      tick(1);
      chk("bclk", {6'h00, bck}, 8'(i));
      chk("stream", {6'h00, spo, ifo}, 8'h02);
    end
    i_host.wr(7'h13, 8'h01);
    bz = 1'h1;
    tick(1);
    chk("mute", {7'h00, zhm}, 8'h00);
    i_host.wr(7'h14, 8'h00);
    tick(1);
    chk("mute", {6'h00, zhm, fbm}, 8'h03);
    bz = 1'h0;
    tick(2);
    chk("mute", {7'h00, zhm}, 8'h00);
    $display("test rate and mute done");
    for (int p = 0; p < 2; p++) begin
      i_host.wr(7'h14, 8'h08 | 8'(p << 2));
      tick(1);
      chk("single_channel_mode", {6'h00, bal, mrs}, 8'h02 | 8'(p));
    end
    i_host.wr(7'h14, 8'h04);
    tick(1);
    chk("single_channel_mode", {6'h00, bal, mrs}, 8'h00);
    i_host.wr(7'h14, 8'h10);
    i_host.wr(7'h13, 8'h04);
    lpin = 1'h1;
    dpin = 1'h1;
    tick(5);
    chk("bypass", {4'h0, oe_n, ifo, bl, br}, 8'h0A);
    i_host.wr(7'h13, 8'h00);
    tick(5);
    chk("bypass", {5'h00, oe_n, bmi, bl}, 8'h03);
    i_host.wr(7'h14, 8'h00);
    $display("test single_channel_mode and bypass done");
    zd_l = 3'h4;
    tick(2);
    chk("flags", {6'h00, rout, lout}, 8'h01);
    rdchk(7'h16, 8'h01);
    i_host.wr(7'h15, 8'h00);
    tick(1);
    chk("flags", {6'h00, rout, lout}, 8'h00);
    i_host.wr(7'h14, 8'h20);
    zd_l = 3'h2;
    zd_r = 3'h1;
    for (int z = 0; z < 3; z++) begin
      i_host.wr(7'h15, 8'(z << 1));
      tick(1);
      chk("pattern", {6'h00, rout, lout}, 8'(z));
      rdchk(7'h16, 8'(z));
    end
    $display("test zero flags done");
    i_host.wr(7'h16, 8'hFF);
    i_host.wr(7'h17, 8'h00);
    rdchk(7'h16, 8'h02);
    rdchk(7'h17, {3'h0, ID});
    i_host.wr(7'h14, 8'h08);
    rdchk(7'h14, 8'h08);
    i_host.wr(7'h14, 8'h48);
    chk("soft_reset", {7'h00, srp}, 8'h01);
    tick(1);
    chk("soft_reset", {7'h00, srp}, 8'h00);
    rdchk(7'h14, 8'h00);
    rdchk(7'h15, 8'h01);
    $display("test soft reset done");
    give_verdict();
  end
endmodule : tb_top
